// >>> design/spp_core.sv
/*
 * byte-wide serial peripheral port, controller or target, with register
 * port, clock generator, shifter, receive buffer and pin direction logic.
 * assumes a register master that follows the one-cycle strobe protocol
 * and pins resolved outside from each output and active-low enable.
 */
// Overview of operation
// - controller: data write starts eight-bit shift
// - controller: clock halts, done flag sets
// - done flag with enable raises interrupt
// - full duplex, fixed data line directions
// - last received byte kept in buffer
// - target idle, output released while deselected
// - target loads data, shifts only when selected
// - target sets done flag after full byte
// - target may load before reading received
// - read each byte before next arrives
// - enabled port forces pin directions
// - double rate halves each divider, /4 becomes /2
// - input select low as controller forces target
// - done flag cleared by ack or sequence
// - rate bits divide by 4/16/64/128
// - polarity and phase give four modes
`timescale 1ns/10ps
`default_nettype none
module spp_core
(
   input  wire logic                        i_core_clk,
   input  wire logic                        i_rst,
   input  wire logic                        i_ce,
   input  wire logic [spp_pkg::ADDR_W-1:0]  i_addr,
   input  wire logic [spp_pkg::DATA_W-1:0]  i_wdata,
   input  wire logic                        i_wr,
   input  wire logic                        i_rd,
   output logic      [spp_pkg::DATA_W-1:0]  o_rdata,
   output logic                             o_irq,
   input  wire logic                        i_irq_ack,
   input  wire logic                        i_mosi,
   output logic                             o_mosi,
   output logic                             o_mosi_oe_n,
   input  wire logic                        i_miso,
   output logic                             o_miso,
   output logic                             o_miso_oe_n,
   input  wire logic                        i_sck,
   output logic                             o_sck,
   output logic                             o_sck_oe_n,
   input  wire logic                        i_ss_n,
   output logic                             o_ss_n,
   output logic                             o_ss_n_oe_n
);
   import spp_pkg::*;

   // half period of the controller clock for a rate setting
   function automatic logic [6:0] half_cycles(input logic [1:0] rate,
                                              input logic       dbl);
      logic [6:0] base;
      base = HALF_R0;
      unique case (rate)
         2'd0: base = HALF_R0;
         2'd1: base = HALF_R1;
         2'd2: base = HALF_R2;
         2'd3: base = HALF_R3;
      endcase
      return dbl ? (base >> 1) : base;
   endfunction

   // shift one bit in at the end away from the outgoing bit
   function automatic logic [7:0] shift_in(input logic [7:0] sh,
                                           input logic       b,
                                           input logic       lsb_first);
      return lsb_first ? {b, sh[7:1]} : {sh[6:0], b};
   endfunction

   spp_sync_if sif ();

   spp_pin_sync #(.STAGES(SYNC_STAGES)) u_sync
   (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_ce       (i_ce),
      .sif        (sif.sync_side)
   );

   assign sif.raw = {i_ss_n, i_sck, i_miso, i_mosi};

   logic [7:0] ctrl_ff;
   logic       dbl_ff;
   logic       gate_ff;
   logic [7:0] pindir_ff;
   logic       flag_ff;
   logic       write_collision_flag_ff;
   logic       arm_ff;
   logic [7:0] rdata_ff;
   logic [7:0] sh_ff;
   logic [7:0] tx_hold_ff;
   logic [7:0] rxbuf_ff;
   logic [2:0] bit_cnt_ff;
   logic       pend_ff;
   logic       samp_ff;
   logic       run_ff;
   logic [3:0] edge_idx_ff;
   logic [6:0] half_cnt_ff;
   logic       sck_ff;
   logic       sck_d_ff;
   logic       ss_d_ff;

   logic       enabled;
   logic       ctrl_mode;
   logic       tgt_mode;
   logic       cpol;
   logic       cpha;
   logic       lsb_first;
   logic       ss_in;
   logic       sck_in;
   logic       wr_ctrl;
   logic       wr_stat;
   logic       wr_data;
   logic       rd_stat;
   logic       rd_data;
   logic       busy;
   logic       start;
   logic       tick;
   logic       lead_ev;
   logic       trail_ev;
   logic       samp_ev;
   logic       setup_ev;
   logic       in_bit;
   logic       byte_done;
   logic       ctrl_end;
   logic       mode_fault;
   logic       flag_set;
   logic       flag_clr;
   logic       ss_rise;
   logic       tgt_sel;

   // decoded control and register strobes
   assign enabled   = ctrl_ff[CTRL_ENABLE] & ~gate_ff;
   assign ctrl_mode = enabled & ctrl_ff[CTRL_CTRLSEL];
   assign tgt_mode  = enabled & ~ctrl_ff[CTRL_CTRLSEL];
   assign cpol      = ctrl_ff[CTRL_CPOL];
   assign cpha      = ctrl_ff[CTRL_CPHA];
   assign lsb_first = ctrl_ff[CTRL_BIT_ORD];
   assign ss_in     = sif.sync[PIN_SS];
   assign sck_in    = sif.sync[PIN_SCK];
   assign wr_ctrl   = i_wr & (i_addr == OFS_CTRL);
   assign wr_stat   = i_wr & (i_addr == OFS_STATUS);
   assign wr_data   = i_wr & (i_addr == OFS_DATA);
   assign rd_stat   = i_rd & (i_addr == OFS_STATUS);
   assign rd_data   = i_rd & (i_addr == OFS_DATA);
   assign tgt_sel   = tgt_mode & ~ss_in;

   // transmit has one buffer, so a byte in flight blocks new data
   assign busy  = run_ff | pend_ff | (bit_cnt_ff != 3'h0);
   assign start = wr_data & ctrl_mode & ~busy & ~mode_fault;

   // select pulled low on an input select pin while controller
   assign mode_fault = ctrl_mode & ~pindir_ff[PIN_SS] & ~ss_in;
   assign ss_rise    = ss_in & ~ss_d_ff;

   // controller clock divider tick
   assign tick = run_ff & (half_cnt_ff == 7'h00);

   // leading and trailing edges, generated or seen on the pin
   always_comb
   begin
      lead_ev  = 1'b0;
      trail_ev = 1'b0;
      if (ctrl_mode)
      begin
         lead_ev  = tick & ~edge_idx_ff[0];
         trail_ev = tick & edge_idx_ff[0];
      end
      else if (tgt_sel)
      begin
         lead_ev  = (sck_in != sck_d_ff) & (sck_d_ff == cpol);
         trail_ev = (sck_in != sck_d_ff) & (sck_d_ff != cpol);
      end
   end

   // sample on one edge, set up on the other
   assign samp_ev  = cpha ? trail_ev : lead_ev;
   assign setup_ev = cpha ? lead_ev : trail_ev;
   assign in_bit   = ctrl_mode ? sif.sync[PIN_MISO]
                               : sif.sync[PIN_MOSI];
   assign byte_done = samp_ev & (bit_cnt_ff == LAST_BIT);
   assign ctrl_end  = tick & (edge_idx_ff == LAST_EDGE);

   // done flag sources and clear paths
   assign flag_set = (ctrl_mode & ctrl_end)
                   | (tgt_mode & byte_done)
                   | mode_fault;
   assign flag_clr = i_irq_ack | (arm_ff & (rd_data | wr_data));

   // interrupt request follows the flag
   assign o_irq = flag_ff & ctrl_ff[CTRL_IRQ_EN];

   // control register; a mode fault overrides the select bit
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         ctrl_ff <= CTRL_RST;
      else if (i_ce)
      begin
         if (wr_ctrl)
            ctrl_ff <= i_wdata;
         if (mode_fault)
            ctrl_ff[CTRL_CTRLSEL] <= 1'b0;
      end
   end

   // double rate, power gate and pin directions
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         dbl_ff    <= 1'b0;
         gate_ff   <= PWR_GATE_RST;
         pindir_ff <= PINDIR_RST;
      end
      else if (i_ce)
      begin
         if (wr_stat)
            dbl_ff <= i_wdata[STAT_DBL];
         if (i_wr & (i_addr == OFS_POWER))
            gate_ff <= i_wdata[PWR_GATE];
         if (i_wr & (i_addr == OFS_PINDIR))
            pindir_ff <= i_wdata;
      end
   end

   // done and collision flags: a set in the clearing cycle wins
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         flag_ff <= 1'b0;
         write_collision_flag_ff <= 1'b0;
         arm_ff  <= 1'b0;
      end
      else if (i_ce)
      begin
         if (flag_set)
            flag_ff <= 1'b1;
         else if (flag_clr)
            flag_ff <= 1'b0;
         if (wr_data & busy)
            write_collision_flag_ff <= 1'b1;
         else if (arm_ff & (rd_data | wr_data))
            write_collision_flag_ff <= 1'b0;
         if (rd_stat & flag_ff)
            arm_ff <= 1'b1;
         else if (rd_data | wr_data | i_irq_ack)
            arm_ff <= 1'b0;
      end
   end

   // read data, valid in the cycle after the strobe only
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         rdata_ff <= 8'h00;
      else if (i_ce)
      begin
         rdata_ff <= 8'h00;
         if (i_rd)
         begin
            unique case (i_addr)
               OFS_CTRL:   rdata_ff <= ctrl_ff;
               OFS_STATUS: rdata_ff <= {flag_ff, write_collision_flag_ff, 5'h00, dbl_ff};
               OFS_DATA:   rdata_ff <= rxbuf_ff;
               OFS_POWER:  rdata_ff <= {7'h00, gate_ff};
               OFS_PINDIR: rdata_ff <= pindir_ff;
               default:    rdata_ff <= 8'h00;
            endcase
         end
      end
   end

   assign o_rdata = rdata_ff;

   // controller clock generator: sixteen edges then stop
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         run_ff      <= 1'b0;
         edge_idx_ff <= 4'h0;
         half_cnt_ff <= 7'h00;
         sck_ff      <= 1'b0;
      end
      else if (i_ce)
      begin
         if (!ctrl_mode || mode_fault)
         begin
            run_ff <= 1'b0;
            sck_ff <= cpol;
         end
         else if (start)
         begin
            run_ff      <= 1'b1;
            edge_idx_ff <= 4'h0;
            half_cnt_ff <= half_cycles(ctrl_ff[CTRL_RATE_HI:CTRL_RATE_LO],
                                       dbl_ff) - 7'h01;
         end
         else if (tick)
         begin
            sck_ff      <= ~sck_ff;
            edge_idx_ff <= edge_idx_ff + 4'h1;
            half_cnt_ff <= half_cycles(ctrl_ff[CTRL_RATE_HI:CTRL_RATE_LO],
                                       dbl_ff) - 7'h01;
            if (ctrl_end)
               run_ff <= 1'b0;
         end
         else if (run_ff)
            half_cnt_ff <= half_cnt_ff - 7'h01;
         else
            sck_ff <= cpol;
      end
   end

   // edge history of the settled target clock and select
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sck_d_ff <= 1'b0;
         ss_d_ff  <= 1'b1;
      end
      else if (i_ce)
      begin
         sck_d_ff <= sck_in;
         ss_d_ff  <= ss_in;
      end
   end

   // shifter: sample into a holding bit, shift on the setup edge
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sh_ff      <= 8'h00;
         tx_hold_ff <= 8'h00;
         bit_cnt_ff <= 3'h0;
         pend_ff    <= 1'b0;
         samp_ff    <= 1'b0;
      end
      else if (i_ce)
      begin
         if (!enabled || mode_fault || (tgt_mode && ss_rise))
         begin
            // drop a partial byte, restore the byte to send
            sh_ff      <= tx_hold_ff;
            bit_cnt_ff <= 3'h0;
            pend_ff    <= 1'b0;
         end
         else if (wr_data && !busy)
         begin
            sh_ff      <= i_wdata;
            tx_hold_ff <= i_wdata;
         end
         else if (samp_ev)
         begin
            if (byte_done)
            begin
               // last bit goes only to the buffer: moving the
               // output line here would race the far end's sample
               bit_cnt_ff <= 3'h0;
               pend_ff    <= 1'b0;
            end
            else
            begin
               samp_ff    <= in_bit;
               pend_ff    <= 1'b1;
               bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end
         end
         else if (setup_ev && pend_ff)
         begin
            sh_ff   <= shift_in(sh_ff, samp_ff, lsb_first);
            pend_ff <= 1'b0;
         end
      end
   end

   // receive buffer overwritten by each completed byte
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         rxbuf_ff <= 8'h00;
      else if (i_ce && enabled && byte_done && !mode_fault)
         rxbuf_ff <= shift_in(sh_ff, in_bit, lsb_first);
   end

   // outgoing bit is the end that leaves first
   assign o_mosi = lsb_first ? sh_ff[0] : sh_ff[7];
   assign o_miso = lsb_first ? sh_ff[0] : sh_ff[7];
   assign o_sck  = sck_ff;
   assign o_ss_n = pindir_ff[PIN_SS_LVL];

   // pin direction overrides, enables are active low
   always_comb
   begin
      o_mosi_oe_n = 1'b1;
      o_miso_oe_n = 1'b1;
      o_sck_oe_n  = 1'b1;
      o_ss_n_oe_n = ~pindir_ff[PIN_SS];
      if (ctrl_mode)
      begin
         o_mosi_oe_n = ~pindir_ff[PIN_MOSI];
         o_sck_oe_n  = ~pindir_ff[PIN_SCK];
      end
      else if (tgt_mode)
      begin
         o_ss_n_oe_n = 1'b1;
         o_miso_oe_n = ~(pindir_ff[PIN_MISO] & ~ss_in);
      end
   end

endmodule
`default_nettype wire

// >>> shared/spp_pkg.sv
/*
 * constants for the serial peripheral port: register offsets, field
 * positions, reset values, clock-rate counts and pin vector positions.
 * assumes an 8-bit register port with 8-bit addresses.
 */
`default_nettype none
package spp_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [7:0] OFS_CTRL   = 8'h2C;
   localparam logic [7:0] OFS_STATUS = 8'h2D;
   localparam logic [7:0] OFS_DATA   = 8'h2E;
   localparam logic [7:0] OFS_POWER  = 8'h30;
   localparam logic [7:0] OFS_PINDIR = 8'h31;

   // control register fields
   localparam int CTRL_IRQ_EN   = 7;
   localparam int CTRL_ENABLE   = 6;
   localparam int CTRL_BIT_ORD  = 5;
   localparam int CTRL_CTRLSEL  = 4;
   localparam int CTRL_CPOL     = 3;
   localparam int CTRL_CPHA     = 2;
   localparam int CTRL_RATE_HI  = 1;
   localparam int CTRL_RATE_LO  = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;

   // status register fields
   localparam int STAT_DONE  = 7;
   localparam int STAT_WRITE_COLLISION_FLAG  = 6;
   localparam int STAT_DBL   = 0;

   // power gate: bit 0, reset value lets the port run
   localparam int         PWR_GATE     = 0;
   localparam logic       PWR_GATE_RST = 1'b0;

   // pin direction register: one means driven by the port, except bit 4, which sets the select output level
   localparam int PIN_MOSI   = 0;
   localparam int PIN_MISO   = 1;
   localparam int PIN_SCK    = 2;
   localparam int PIN_SS     = 3;
   localparam int PIN_SS_LVL = 4;
   localparam logic [7:0] PINDIR_RST = 8'h10;

   // half periods of the serial clock in system clocks (/4 /16 /64 /128)
   localparam logic [6:0] HALF_R0 = 7'h02;
   localparam logic [6:0] HALF_R1 = 7'h08;
   localparam logic [6:0] HALF_R2 = 7'h20;
   localparam logic [6:0] HALF_R3 = 7'h40;

   // last edge index per byte in controller mode, last bit index
   localparam logic [3:0] LAST_EDGE = 4'hF;
   localparam logic [2:0] LAST_BIT  = 3'h7;

   // least clock phase a target can sample, in system clocks
   localparam int SCK_MIN_PHASE_CYC = 2;

   // synchroniser depth for pin inputs
   localparam int SYNC_STAGES = 2;

endpackage
`default_nettype wire

// >>> shared/spp_sync_if.sv
/*
 * carries raw pin levels into the synchroniser and the settled levels
 * back out. assumes one clock domain on the core side.
 */
`timescale 1ns/10ps
`default_nettype none
interface spp_sync_if;
   logic [3:0] raw;
   logic [3:0] sync;
   modport core (output raw, input sync);
   modport sync_side (input raw, output sync);
endinterface
`default_nettype wire

// >>> design/spp_pin_sync.sv
/*
 * multi-flop synchroniser for the four serial pin inputs.
 * assumes the pins are asynchronous to i_core_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module spp_pin_sync
#(
   parameter int STAGES = spp_pkg::SYNC_STAGES
)
(
   input  wire logic   i_core_clk,
   input  wire logic   i_rst,
   input  wire logic   i_ce,
   spp_sync_if.sync_side sif
);
   import spp_pkg::*;

   logic [3:0] stage_ff [STAGES];

   // fewer than two flops leaves metastability to the logic
   if (STAGES < 2)
   begin : g_chk
      $error("spp_pin_sync needs at least two stages");
   end

   // first stage is read only by the second
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         for (int i = 0; i < STAGES; i++)
            stage_ff[i] <= 4'h0;
      end
      else if (i_ce)
      begin
         stage_ff[0] <= sif.raw;
         for (int i = 1; i < STAGES; i++)
            stage_ff[i] <= stage_ff[i-1];
      end
   end

   assign sif.sync = stage_ff[STAGES-1];

endmodule
`default_nettype wire

// >>> verif/spp_core_properties.sv
/* port checker for spp_core.
   assumes one clock domain and an async active-high reset. */
`timescale 1ns/10ps
`default_nettype none
module spp_core_props
   import spp_pkg::*;
(
   input wire logic       i_core_clk,
   input wire logic       i_rst,
   input wire logic [7:0] i_addr,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic       o_irq,
   input wire logic       i_irq_ack,
   input wire logic       i_ss_n,
   input wire logic       o_ss_n,
   input wire logic       o_sck,
   input wire logic       o_sck_oe_n,
   input wire logic       o_mosi_oe_n,
   input wire logic       o_miso_oe_n,
   input wire logic       o_ss_n_oe_n
);
   // single domain, so one clocking and one disable for all
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   // read data stands only in the cycle after a read strobe
   a_rdata_idle: assert property (
      !$past(i_rd) |-> o_rdata == 8'h00) else $error("stray read data");
   // a data write as controller must get the clock moving
   a_sck_start: assert property (
      i_wr && i_addr == OFS_DATA && !o_sck_oe_n |-> ##[1:130] $changed(o_sck))
      else $error("serial clock never started");
   // clock has stopped when the flag shows
   a_sck_halt: assert property (
      $rose(o_irq) && !o_sck_oe_n |=> $stable(o_sck) [*3])
      else $error("serial clock still running after done");
   // select output moves only by software
   a_ss_sw_only: assert property (
      $changed(o_ss_n) |-> $past(i_wr)) else $error("select moved alone");
   // deselected target leaves controller-in floating
   a_miso_release: assert property (
      i_ss_n [*4] |-> o_miso_oe_n) else $error("miso driven while idle");
   // driving the clock means controller, so controller-in is input
   a_miso_dir_ctl: assert property (
      !o_sck_oe_n |-> o_miso_oe_n) else $error("miso driven as controller");
   a_pins_dir_tgt: assert property (
      !o_miso_oe_n |-> o_mosi_oe_n && o_sck_oe_n && o_ss_n_oe_n)
      else $error("target drives an input pin");
   // vector taken drops the request next cycle
   a_ack_clears: assert property (
      i_irq_ack && o_irq |=> !o_irq) else $error("ack left flag set");

   c_irq: cover property ($rose(o_irq));
   c_tgt: cover property (!o_miso_oe_n);
   c_ack: cover property (i_irq_ack && o_irq);
endmodule
`default_nettype wire

// >>> verif/spp_far_target.sv
/* far-side target model, msb first, any of the four clock modes.
   assumes clock and select arrive as resolved pin levels. */
`timescale 1ns/10ps
`default_nettype none
module spp_far_target
(
   input  wire logic       i_sck,
   input  wire logic       i_mosi,
   input  wire logic       i_ss_n,
   input  wire logic [1:0] i_mode,
   input  wire logic [7:0] i_tx,
   output logic            o_miso,
   output logic [7:0]      o_rx
);
   logic [7:0] sh = 8'h00;

   initial o_miso = 1'b1;
   // load on select, first bit out at once
   always @(negedge i_ss_n)
   begin
      sh = i_tx;
      o_miso = sh[7];
   end
   // released line must not look like held data
   always @(posedge i_ss_n)
      o_miso = ~o_miso;
   // sample level is ~(cpol ^ cpha); setup on the other edge
   always @(i_sck)
      if (!i_ss_n && i_sck == ~(i_mode[1] ^ i_mode[0]))
      begin
         sh = {sh[6:0], i_mosi};
         o_rx = sh;
      end
      else if (!i_ss_n)
         o_miso = sh[7];
endmodule
`default_nettype wire

// >>> verif/tb_serial_peripheral_port.sv
/* self-checking bench for spp_core and its far target.
   assumes pins resolve from each output and active-low enable. */
`timescale 1ns/10ps
`default_nettype none
module tb_serial_peripheral_port;
   import spp_pkg::*;
   logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ack = 1'b0;
   logic       tb_sck = 1'b0, tb_mosi = 1'b0, tb_ss = 1'b1;
   logic [7:0] addr = 8'h00, wdata = 8'h00, far_tx = 8'h00, v;
   logic [7:0] rdata, far_rx;
   logic       irq, mosi, mosi_oe_n, miso, miso_oe_n, far_miso;
   logic       sck, sck_oe_n, ss, ss_oe_n;
   logic [1:0] far_mode = 2'b00;
   int         n_fail = 0, check_count = 0;
   int         hh[4] = '{2, 8, 32, 64};
   wire logic  sck_w = sck_oe_n ? tb_sck : sck;
   wire logic  mosi_w = mosi_oe_n ? tb_mosi : mosi;
   wire logic  miso_w = miso_oe_n ? far_miso : miso;
   wire logic  ss_w = ss_oe_n ? tb_ss : ss;

   spp_core u_dut (.i_core_clk(clk), .i_rst(rst), .i_ce(1'b1),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .o_irq(irq), .i_irq_ack(ack), .i_mosi(mosi_w), .o_mosi(mosi),
      .o_mosi_oe_n(mosi_oe_n), .i_miso(miso_w), .o_miso(miso),
      .o_miso_oe_n(miso_oe_n), .i_sck(sck_w), .o_sck(sck),
      .o_sck_oe_n(sck_oe_n), .i_ss_n(ss_w), .o_ss_n(ss),
      .o_ss_n_oe_n(ss_oe_n));
   spp_far_target u_far (.i_sck(sck_w), .i_mosi(mosi_w), .i_ss_n(ss_w),
      .i_mode(far_mode), .i_tx(far_tx), .o_miso(far_miso), .o_rx(far_rx));

   // 50 ns system clock
   initial
   begin
      forever #25 clk = ~clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      if (n_fail == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // answer is sampled mid-cycle, the only cycle it stands
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   // bounded wait; a hang ends the run as a failure
   task automatic wait_irq(output int n);
      n = 0;
      while (irq !== 1'b1)
      begin
         @(negedge clk);
         n++;
         if (n > 3000)
         begin
            chk(8'h00, 8'h01);
            finish_test();
         end
      end
   endtask

   function automatic logic [7:0] rev(input logic [7:0] x);
      return {<<{x}};
   endfunction

   // one framed controller byte; coll adds a write while busy
   task automatic ctl_xfer(input logic [7:0] ctl, input logic dbl,
      input logic coll, input int h);
      int n;
      far_mode = ctl[3:2];
      far_tx = ctl ^ 8'h3C;
      wr_reg(OFS_STATUS, {7'h00, dbl});
      wr_reg(OFS_CTRL, ctl);
      wr_reg(OFS_PINDIR, 8'h0D);
      wr_reg(OFS_DATA, ctl ^ 8'hA6);
      if (coll)
         wr_reg(OFS_DATA, 8'hFF);
      wait_irq(n);
      chk(8'(n >= 16*h-2 && n <= 16*h+2), 8'h01);
      rd_reg(OFS_STATUS, v);
      chk(v, {1'b1, coll, 5'h00, dbl});
      rd_reg(OFS_DATA, v);
      // synced input lags: far data must settle three cycles early
      if (h > 2)
         chk(v, ctl[5] ? rev(far_tx) : far_tx);
      chk(far_rx, ctl[5] ? rev(ctl ^ 8'hA6) : ctl ^ 8'hA6);
      rd_reg(OFS_STATUS, v);
      chk(v, {7'h00, dbl});
      wr_reg(OFS_PINDIR, 8'h1D);
   endtask

   // select pin as input pulled low while controller
   task automatic mode_fault();
      int n;
      wr_reg(OFS_PINDIR, 8'h10);
      wr_reg(OFS_CTRL, 8'hD0);
      tb_ss <= 1'b0;
      wait_irq(n);
      chk(8'(n <= 6), 8'h01);
      rd_reg(OFS_CTRL, v);
      chk(v, 8'hC0);
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      tb_ss <= 1'b1;
      rd_reg(OFS_STATUS, v);
      chk(v, 8'h00);
   endtask

   // bench plays controller, phases of 3 and 4 cycles
   task automatic tgt_xfer(input logic [7:0] d, input logic [7:0] c);
      logic [7:0] got;
      int         n;
      wr_reg(OFS_CTRL, 8'hC0);
      wr_reg(OFS_PINDIR, 8'h12);
      wr_reg(OFS_DATA, d);
      repeat (8)
      begin
         repeat (3) @(posedge clk);
         tb_sck <= ~tb_sck;
      end
      chk({7'h00, miso_oe_n}, 8'h01);
      chk({7'h00, irq}, 8'h00);
      tb_ss <= 1'b0;
      for (int b = 7; b >= 0; b--)
      begin
         tb_mosi <= c[b];
         repeat (4) @(posedge clk);
         got[b] = miso;
         tb_sck <= 1'b1;
         repeat (4) @(posedge clk);
         tb_sck <= 1'b0;
      end
      chk({7'h00, miso_oe_n}, 8'h00);
      wait_irq(n);
      chk(8'(n), 8'h00);
      chk(got, d);
      wr_reg(OFS_DATA, ~d);
      rd_reg(OFS_STATUS, v);
      chk(v, 8'h80);
      chk({7'h00, miso}, {7'h00, ~d[7]});
      rd_reg(OFS_DATA, v);
      chk(v, c);
      @(posedge clk);
      tb_ss <= 1'b1;
      tb_mosi <= ~tb_mosi;
   endtask

   // main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd_reg(OFS_CTRL, v);
      chk(v, 8'h00);
      rd_reg(OFS_PINDIR, v);
      chk(v, 8'h10);
      rd_reg(OFS_POWER, v);
      chk(v, 8'h00);
      rd_reg(8'h00, v);
      chk(v, 8'h00);
      ctl_xfer(8'hD1, 1'b0, 1'b1, 8);
      ctl_xfer(8'hF1, 1'b0, 1'b0, 8);
      mode_fault();
      tgt_xfer(8'h96, 8'h3A);
      for (int i = 0; i < 8; i++)
         ctl_xfer(8'hD0 | 8'({i[1:0], i[1:0]}), i[2], 1'b0,
            hh[i[1:0]] >> i[2]);
      finish_test();
   end
endmodule

bind spp_core spp_core_props u_props (.i_core_clk(i_core_clk),
   .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
   .o_rdata(o_rdata), .o_irq(o_irq), .i_irq_ack(i_irq_ack),
   .i_ss_n(i_ss_n), .o_ss_n(o_ss_n), .o_sck(o_sck),
   .o_sck_oe_n(o_sck_oe_n), .o_mosi_oe_n(o_mosi_oe_n),
   .o_miso_oe_n(o_miso_oe_n), .o_ss_n_oe_n(o_ss_n_oe_n));
`default_nettype wire
